// [can_cmd_pkg.sv]
package can_cmd_pkg;
    // Characters
    localparam logic [7:0] CHAR_CR   = 8'h0d;
    localparam logic [7:0] CHAR_BELL = 8'h07;
    // Parser buffer: letter plus up to eight hex digits
    localparam int         BUF_LEN   = 9;
    localparam logic [3:0] BUF_LAST  = 4'h8;
    // Selector limits and reset values
    localparam logic [3:0] SEL_MAX        = 4'h8;
    localparam logic [3:0] BAUD_SEL_RESET = 4'h2;
    localparam logic [3:0] CAN_SEL_RESET  = 4'h8;
    // Acceptance reset values
    localparam logic [10:0] MASK_STD_RESET = 11'h000;
    localparam logic [28:0] MASK_EXT_RESET = 29'h0000_0000;
    localparam logic [10:0] FILT_STD_RESET = 11'h7ff;
    localparam logic [28:0] FILT_EXT_RESET = 29'h1fff_ffff;
    // Controller clock for raw bit timing
    localparam int CTRL_CLOCK_HZ = 24_000_000;
    // Core clock and indicator timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int FLASH_HALF_MS  = 250;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
    // Help text length
    localparam logic [4:0] HELP_LEN = 5'h14;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_TIMING   = 8'h04;
    localparam logic [7:0] OFS_MASK_STD = 8'h08;
    localparam logic [7:0] OFS_FILT_STD = 8'h0c;
    localparam logic [7:0] OFS_MASK_EXT = 8'h10;
    localparam logic [7:0] OFS_FILT_EXT = 8'h14;
    localparam logic [7:0] OFS_LAST_ID  = 8'h18;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_EXEC  = 4'b0010,
        ST_HELP  = 4'b0100,
        ST_REPLY = 4'b1000
    } parse_state_t;
endpackage

// [can_cmd_parser.sv]
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module can_cmd_parser #(
    parameter int unsigned FLASH_HALF = can_cmd_pkg::FLASH_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Characters from the UART receiver
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    // Characters to the UART transmitter
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    // Nonvolatile serial rate store
    input  wire logic        nv_valid,
    input  wire logic [3:0]  nv_baud_sel,
    output logic             nv_write,
    output logic      [3:0]  nv_wdata,
    // Configuration to UART and CAN controller
    output logic      [3:0]  baud_sel,
    output logic      [3:0]  can_rate_sel,
    output logic             can_timing_raw,
    output logic      [7:0]  bit_timing_config_first,
    output logic      [7:0]  bit_timing_config_second,
    output logic      [7:0]  bit_timing_config_third,
    output logic             cfg_update,
    // Received frames
    input  wire logic        frame_valid,
    input  wire logic        frame_ext,
    input  wire logic [28:0] frame_id,
    output logic             fwd_valid,
    output logic      [28:0] fwd_id,
    output logic             fwd_ext,
    // Error indicator, low when lit
    output logic             led_err_n
);
    can_cmd_pkg::parse_state_t state;
    logic [7:0]  cmd_buf [can_cmd_pkg::BUF_LEN];
    logic [3:0]  buf_cnt;
    logic        overflow;
    logic [7:0]  reply;
    logic [4:0]  help_idx;
    logic [10:0] mask_std;
    logic [28:0] mask_ext;
    logic [10:0] filt_std;
    logic [10:0] filt_std_q;
    logic [28:0] filt_ext;
    logic        boot_pending;
    logic        flash_start;
    logic [3:0]  flash_left;
    logic        flash_on;
    logic [31:0] flash_timer;

    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_nib = {1'b0, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            hex_nib = {1'b0, c[3:0] + 4'h9};
        end else begin
            hex_nib = 5'h10;
        end
    endfunction

    function automatic logic [7:0] help_char(input logic [4:0] i);
        unique case (i)
            5'h00: help_char = "O";
            5'h01: help_char = "C";
            5'h02: help_char = "t";
            5'h03: help_char = "T";
            5'h04: help_char = "F";
            5'h05: help_char = "V";
            5'h06: help_char = "N";
            5'h07: help_char = "Z";
            5'h08: help_char = "S";
            5'h09: help_char = "s";
            5'h0a: help_char = "m";
            5'h0b: help_char = "M";
            5'h0c: help_char = "B";
            5'h0d: help_char = "L";
            5'h0e: help_char = "E";
            5'h0f: help_char = "R";
            5'h10: help_char = "U";
            5'h11: help_char = "H";
            5'h12: help_char = "h";
            default: help_char = "?";
        endcase
    endfunction

    // Parameter decode
    logic [7:0]  letter;
    logic [3:0]  nargs;
    logic [31:0] acc8;
    logic [11:0] acc3;
    logic [23:0] acc6;
    logic        bad3;
    logic        bad6;
    logic        bad8;
    logic [4:0]  nib;
    logic [3:0]  digit;
    logic        digit_ok;
    always_comb begin
        letter = cmd_buf[0];
        nargs  = buf_cnt - 4'h1;
        acc8   = 32'h0000_0000;
        bad3   = 1'b0;
        bad6   = 1'b0;
        bad8   = 1'b0;
        for (int k = 1; k < can_cmd_pkg::BUF_LEN; k++) begin
            nib  = hex_nib(cmd_buf[k]);
            acc8 = {acc8[27:0], nib[3:0]};
            bad8 = bad8 | nib[4];
            if (k <= 3) begin
                bad3 = bad3 | nib[4];
            end
            if (k <= 6) begin
                bad6 = bad6 | nib[4];
            end
        end
        acc3     = acc8[31:20];
        acc6     = acc8[31:8];
        nib      = hex_nib(cmd_buf[1]);
        digit    = nib[3:0];
        digit_ok = (nargs == 4'h1) && !nib[4] && (digit <= can_cmd_pkg::SEL_MAX);
    end

    logic arg_std;
    logic arg_ext;
    assign arg_std = (nargs == 4'h3) && !bad3 && (acc3[11:11] == 1'b0);
    assign arg_ext = (nargs == 4'h8) && !bad8 && (acc8[31:29] == 3'h0);

    // Outcome of the buffered command
    logic ok_u;
    logic ok_s;
    logic ok_raw;
    logic ok_m;
    logic ok_f;
    logic ok_help;
    logic ok_rst;
    logic exec_ok;
    assign ok_u    = !overflow && letter == "U" && digit_ok;
    assign ok_s    = !overflow && letter == "S" && digit_ok;
    assign ok_raw  = !overflow && letter == "s" && nargs == 4'h6 && !bad6;
    assign ok_m    = !overflow && letter == "m" && (arg_std || arg_ext);
    assign ok_f    = !overflow && letter == "M" && (arg_std || arg_ext);
    assign ok_help = !overflow && nargs == 4'h0
                     && (letter == "H" || letter == "h" || letter == "?");
    assign ok_rst  = !overflow && nargs == 4'h0 && letter == "R";
    assign exec_ok = ok_u | ok_s | ok_raw | ok_m | ok_f | ok_help | ok_rst;

    logic exec;
    assign exec = state == can_cmd_pkg::ST_EXEC;

    // Input side: buffer until CR, never echo
    assign rx_ready = state == can_cmd_pkg::ST_IDLE;
    logic rx_take;
    assign rx_take = rx_valid && rx_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_cnt  <= 4'h0;
            overflow <= 1'b0;
            for (int k = 0; k < can_cmd_pkg::BUF_LEN; k++) begin
                cmd_buf[k] <= 8'h00;
            end
        end else if (exec) begin
            buf_cnt  <= 4'h0;
            overflow <= 1'b0;
        end else if (rx_take && rx_data != can_cmd_pkg::CHAR_CR) begin
            if (buf_cnt > can_cmd_pkg::BUF_LAST) begin
                overflow <= 1'b1;
            end else begin
                cmd_buf[buf_cnt] <= rx_data;
                buf_cnt          <= buf_cnt + 4'h1;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= can_cmd_pkg::ST_IDLE;
            reply    <= 8'h00;
            help_idx <= 5'h00;
        end else begin
            unique case (state)
                can_cmd_pkg::ST_IDLE: begin
                    if (rx_take && rx_data == can_cmd_pkg::CHAR_CR) begin
                        state <= can_cmd_pkg::ST_EXEC;
                    end
                end
                can_cmd_pkg::ST_EXEC: begin
                    help_idx <= 5'h00;
                    reply    <= exec_ok ? can_cmd_pkg::CHAR_CR
                                        : can_cmd_pkg::CHAR_BELL;
                    state    <= ok_help ? can_cmd_pkg::ST_HELP : can_cmd_pkg::ST_REPLY;
                end
                can_cmd_pkg::ST_HELP: begin
                    if (tx_ready) begin
                        if (help_idx == can_cmd_pkg::HELP_LEN - 5'h01) begin
                            state <= can_cmd_pkg::ST_REPLY;
                        end
                        help_idx <= help_idx + 5'h01;
                    end
                end
                can_cmd_pkg::ST_REPLY: begin
                    if (tx_ready) begin
                        state <= can_cmd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Only defined responses reach the transmitter
    always_comb begin
        tx_valid = 1'b0;
        tx_data  = 8'h00;
        if (state == can_cmd_pkg::ST_HELP) begin
            tx_valid = 1'b1;
            tx_data  = help_char(help_idx);
        end else if (state == can_cmd_pkg::ST_REPLY) begin
            tx_valid = 1'b1;
            tx_data  = reply;
        end
    end

    // Serial rate, caught from the store after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_sel     <= can_cmd_pkg::BAUD_SEL_RESET;
            boot_pending <= 1'b1;
            nv_write     <= 1'b0;
            nv_wdata     <= can_cmd_pkg::BAUD_SEL_RESET;
        end else begin
            boot_pending <= 1'b0;
            nv_write     <= exec && ok_u;
            if (boot_pending && nv_valid && nv_baud_sel <= can_cmd_pkg::SEL_MAX) begin
                baud_sel <= nv_baud_sel;
            end else if (exec && ok_u) begin
                baud_sel <= digit;
                nv_wdata <= digit;
            end
        end
    end

    // CAN bit rate, separate from serial rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_rate_sel             <= can_cmd_pkg::CAN_SEL_RESET;
            can_timing_raw           <= 1'b0;
            bit_timing_config_first  <= 8'h00;
            bit_timing_config_second <= 8'h00;
            bit_timing_config_third  <= 8'h00;
        end else if (exec && (ok_s || ok_rst)) begin
            can_rate_sel   <= ok_s ? digit : can_cmd_pkg::CAN_SEL_RESET;
            can_timing_raw <= 1'b0;
        end else if (exec && ok_raw) begin
            can_timing_raw           <= 1'b1;
            bit_timing_config_first  <= acc6[23:16];
            bit_timing_config_second <= acc6[15:8];
            bit_timing_config_third  <= acc6[7:0];
        end else if (psel && penable && pwrite && paddr == can_cmd_pkg::OFS_TIMING) begin
            can_timing_raw           <= 1'b1;
            bit_timing_config_first  <= pwdata[23:16];
            bit_timing_config_second <= pwdata[15:8];
            bit_timing_config_third  <= pwdata[7:0];
        end
    end

    // Settings change only; channel open state is left as it was
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_update <= 1'b0;
        end else begin
            cfg_update <= exec && (ok_s || ok_raw || ok_m || ok_f);
        end
    end

    // Acceptance mask and filter
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_std <= can_cmd_pkg::MASK_STD_RESET;
            mask_ext <= can_cmd_pkg::MASK_EXT_RESET;
            filt_std <= can_cmd_pkg::FILT_STD_RESET;
            filt_ext <= can_cmd_pkg::FILT_EXT_RESET;
        end else if (exec && ok_m) begin
            if (arg_std) begin
                mask_std <= acc3[10:0];
            end else begin
                mask_ext <= acc8[28:0];
            end
        end else if (exec && ok_f) begin
            if (arg_std) begin
                filt_std <= acc3[10:0];
            end else begin
                filt_ext <= acc8[28:0];
            end
        end else if (apb_wr) begin
            if (paddr == can_cmd_pkg::OFS_MASK_STD) begin
                mask_std <= pwdata[10:0];
            end
            if (paddr == can_cmd_pkg::OFS_FILT_STD) begin
                filt_std <= pwdata[10:0];
            end
            if (paddr == can_cmd_pkg::OFS_MASK_EXT) begin
                mask_ext <= pwdata[28:0];
            end
            if (paddr == can_cmd_pkg::OFS_FILT_EXT) begin
                filt_ext <= pwdata[28:0];
            end
        end
    end
    assign filt_std_q = filt_std;

    // Frame acceptance and forwarding
    logic accept;
    always_comb begin
        if (frame_ext) begin
            accept = ((frame_id ^ filt_ext) & mask_ext) == 29'h0000_0000;
        end else begin
            accept = ((frame_id[10:0] ^ filt_std_q) & mask_std) == 11'h000;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_valid <= 1'b0;
            fwd_id    <= 29'h0000_0000;
            fwd_ext   <= 1'b0;
        end else begin
            fwd_valid <= frame_valid && accept;
            if (frame_valid && accept) begin
                fwd_id  <= frame_ext ? frame_id : {18'h0_0000, frame_id[10:0]};
                fwd_ext <= frame_ext;
            end
        end
    end

    // Error indicator flashes selector plus one times
    assign flash_start = boot_pending || (exec && ok_rst);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_left  <= 4'h0;
            flash_on    <= 1'b0;
            flash_timer <= 32'h0000_0000;
        end else if (flash_start) begin
            flash_left  <= (boot_pending && nv_valid && nv_baud_sel <= can_cmd_pkg::SEL_MAX)
                           ? nv_baud_sel + 4'h1 : baud_sel + 4'h1;
            flash_on    <= 1'b0;
            flash_timer <= 32'h0000_0000;
        end else if (flash_left != 4'h0) begin
            if (flash_timer == FLASH_HALF - 1) begin
                flash_timer <= 32'h0000_0000;
                flash_on    <= !flash_on;
                if (flash_on) begin
                    flash_left <= flash_left - 4'h1;
                end
            end else begin
                flash_timer <= flash_timer + 32'h0000_0001;
            end
        end
    end
    assign led_err_n = !flash_on;

    // APB slave, zero wait states
    logic mapped;
    assign mapped  = paddr <= can_cmd_pkg::OFS_LAST_ID && paddr[1:0] == 2'h0;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                can_cmd_pkg::OFS_STATUS:   prdata <= {18'h0_0000, flash_left != 4'h0,
                                                      can_timing_raw, can_rate_sel,
                                                      baud_sel, state};
                can_cmd_pkg::OFS_TIMING:   prdata <= {8'h00, bit_timing_config_first,
                                                      bit_timing_config_second,
                                                      bit_timing_config_third};
                can_cmd_pkg::OFS_MASK_STD: prdata <= {21'h00_0000, mask_std};
                can_cmd_pkg::OFS_FILT_STD: prdata <= {21'h00_0000, filt_std};
                can_cmd_pkg::OFS_MASK_EXT: prdata <= {3'h0, mask_ext};
                can_cmd_pkg::OFS_FILT_EXT: prdata <= {3'h0, filt_ext};
                can_cmd_pkg::OFS_LAST_ID:  prdata <= {2'h0, fwd_ext, fwd_id};
                default:                   prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [can_cmd_parser_monitor.sv]
`timescale 1ns/1ps
module can_cmd_parser_monitor #(
    parameter int unsigned FLASH_HALF = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready,
    input wire logic        nv_write,
    input wire logic [3:0]  nv_wdata,
    input wire logic [3:0]  baud_sel,
    input wire logic [3:0]  can_rate_sel,
    input wire logic        can_timing_raw,
    input wire logic [7:0]  bit_timing_config_first,
    input wire logic        cfg_update,
    input wire logic        frame_valid,
    input wire logic [28:0] frame_id,
    input wire logic        fwd_valid,
    input wire logic [28:0] fwd_id
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_cr_reply: assert property (rx_valid && rx_ready && rx_data == can_cmd_pkg::CHAR_CR
        |-> ##[1:3] tx_valid) else $error("no reply after end of line");
    chk_tx_legal: assert property (tx_valid |-> tx_data inside {8'h0d, 8'h07, "O", "C",
        "t", "T", "F", "V", "N", "Z", "S", "s", "m", "M", "B", "L", "E", "R", "U", "H", "h", "?"})
        else $error("unexpected character sent");
    chk_no_rx_tx: assert property (tx_valid |-> !rx_ready)
        else $error("input taken while replying");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply character dropped");
    chk_sel_range: assert property (baud_sel <= can_cmd_pkg::SEL_MAX
        && can_rate_sel <= can_cmd_pkg::SEL_MAX) else $error("selector out of range");
    chk_rates_apart: assert property ($changed(baud_sel) |-> $stable(can_rate_sel))
        else $error("rates changed together");
    chk_nv_store: assert property (nv_write |-> nv_wdata == baud_sel ##1 !nv_write)
        else $error("bad rate store");
    chk_cfg_pulse: assert property (cfg_update |=> !cfg_update)
        else $error("update pulse too long");
    chk_raw_load: assert property ($changed(bit_timing_config_first) |-> can_timing_raw)
        else $error("timing byte without raw mode");
    chk_fwd_cause: assert property (fwd_valid |-> $past(frame_valid)
        && fwd_id == $past(frame_id)) else $error("forward without frame");
    cover property (fwd_valid);
    cover property (nv_write);
    cover property (cfg_update);
    cover property (tx_valid && tx_data == can_cmd_pkg::CHAR_BELL);
endmodule
bind can_cmd_parser can_cmd_parser_monitor #(.FLASH_HALF(FLASH_HALF)) mon_inst (
    .pclk, .presetn, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .nv_write, .nv_wdata, .baud_sel, .can_rate_sel, .can_timing_raw,
    .bit_timing_config_first, .cfg_update, .frame_valid, .frame_id, .fwd_valid, .fwd_id);

// [host_uart_model.sv]
`timescale 1ns/1ps
module host_uart_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] out_q[$];
    logic [7:0] in_q[$];
    logic       stall;
    // Queue a line; host already follows any new rate
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) out_q.push_back(s[i]);
        out_q.push_back(can_cmd_pkg::CHAR_CR);
    endtask
    always @(posedge pclk or negedge presetn) begin // Host on logic-level port
        if (!presetn) begin
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            tx_ready <= 1'b0;
            stall    <= 1'b0;
        end else begin
            stall    <= ~stall;
            tx_ready <= stall;
            if (tx_valid && tx_ready) in_q.push_back(tx_data);
            if (!rx_valid || rx_ready) begin
                rx_valid <= out_q.size() > 0;
                rx_data  <= (out_q.size() > 0) ? out_q.pop_front() : ~rx_data;
            end
        end
    end
endmodule

// [serial_can_command_parser_test.sv]
`timescale 1ns/1ps
module serial_can_command_parser_test;
    typedef struct {string cmd; logic [7:0] rep; logic [3:0] baud; logic [3:0] can;} row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, rx_data, tx_data;
    logic [31:0] pwdata, prdata, rd;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, nv_valid, led_err_n;
    logic [3:0]  nv_baud_sel, baud_sel, can_rate_sel;
    logic        frame_valid, frame_ext, fwd_valid, fwd_ext;
    logic [28:0] frame_id, fwd_id;
    int          num_errors, samples_checked, flashes;
    row_t        rows [13] = '{'{"U5", 8'h0d, 4'h5, 4'h8}, '{"U9", 8'h07, 4'h5, 4'h8},
        '{"S3", 8'h0d, 4'h5, 4'h3}, '{"R", 8'h0d, 4'h5, 4'h8}, '{"X", 8'h07, 4'h5, 4'h8},
        '{"U", 8'h07, 4'h5, 4'h8}, '{"m700", 8'h0d, 4'h5, 4'h8}, '{"M1FF", 8'h0d, 4'h5, 4'h8},
        '{"M800", 8'h07, 4'h5, 4'h8}, '{"m12", 8'h07, 4'h5, 4'h8}, '{"H1", 8'h07, 4'h5, 4'h8},
        '{"s01BE07", 8'h0d, 4'h5, 4'h8}, '{"S9", 8'h07, 4'h5, 4'h8}};
    string       help = "Hh?";
    can_cmd_parser #(.FLASH_HALF(4)) can_cmd_parser_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
        .nv_valid, .nv_baud_sel, .nv_write(), .nv_wdata(), .baud_sel, .can_rate_sel,
        .can_timing_raw(), .bit_timing_config_first(), .bit_timing_config_second(),
        .bit_timing_config_third(), .cfg_update(), .frame_valid, .frame_ext, .frame_id,
        .fwd_valid, .fwd_id, .fwd_ext, .led_err_n);
    host_uart_model host_uart_model_inst (.pclk, .presetn, .rx_valid, .rx_data, .rx_ready,
        .tx_valid, .tx_data, .tx_ready);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(negedge led_err_n) flashes++;
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checked=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset(input logic v, input logic [3:0] s);
        @(posedge pclk);
        presetn <= 1'b0;
        nv_valid <= v;
        nv_baud_sel <= s;
        repeat (10) @(posedge pclk);
        flashes = 0;
        presetn <= 1'b1;
        repeat (150) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic run_cmd(input string s);
        int n;
        host_uart_model_inst.in_q.delete();
        host_uart_model_inst.send_line(s);
        for (n = 0; n < 500; n++) begin
            @(posedge pclk);
            if (host_uart_model_inst.in_q.size() > 0
                && host_uart_model_inst.in_q[$] inside {8'h0d, 8'h07}) break;
        end
        repeat (4) @(posedge pclk);
        if (n == 500) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic frame(input logic e, input logic [28:0] id, input logic exp);
        @(posedge pclk);
        {frame_valid, frame_ext, frame_id} <= {1'b1, e, id};
        @(posedge pclk);
        frame_valid <= 1'b0;
        #1 compare(fwd_valid, exp);
        if (exp) compare(fwd_id, id);
        if (exp) compare(fwd_ext, e);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, nv_valid, nv_baud_sel} = '0;
        {frame_valid, frame_ext, frame_id} = '0;
        do_reset(1'b0, 4'h0);
        compare(baud_sel, 4'h2);
        compare(flashes, 3);
        foreach (rows[i]) begin
            run_cmd(rows[i].cmd);
            compare(host_uart_model_inst.in_q.size(), 1);
            compare(host_uart_model_inst.in_q[0], rows[i].rep);
            compare(baud_sel, rows[i].baud);
            compare(can_rate_sel, rows[i].can);
        end
        for (int d = 0; d < 9; d++) begin
            run_cmd($sformatf("S%0d", d));
            compare(can_rate_sel, d[3:0]);
            run_cmd($sformatf("U%0d", d));
            compare(baud_sel, d[3:0]);
        end
        for (int i = 0; i < help.len(); i++) begin
            run_cmd(help.substr(i, i));
            compare(host_uart_model_inst.in_q.size(), 21);
            compare(host_uart_model_inst.in_q[0], 8'h4f);
            compare(host_uart_model_inst.in_q[20], 8'h0d);
        end
        apb(1'b0, 8'h04, '0);
        compare(rd, 32'h0001_be07);
        apb(1'b0, 8'h08, '0);
        compare(rd, 32'h0000_0700);
        apb(1'b0, 8'h0c, '0);
        compare(rd, 32'h0000_01ff);
        apb(1'b0, 8'h1c, '0);
        compare(err, 1'b1);
        frame(1'b0, 29'h0000_0123, 1'b1);
        frame(1'b0, 29'h0000_0223, 1'b0);
        frame(1'b1, 29'h0abc_def0, 1'b1);
        apb(1'b1, 8'h10, 32'h1fff_ffff);
        apb(1'b1, 8'h14, 32'h0000_0055);
        frame(1'b1, 29'h0000_0055, 1'b1);
        frame(1'b1, 29'h0000_0054, 1'b0);
        do_reset(1'b1, 4'h5);
        compare(baud_sel, 4'h5);
        compare(can_rate_sel, 4'h8);
        compare(flashes, 6);
        apb(1'b0, 8'h00, '0);
        compare(rd, 32'h0000_0851);
        apb(1'b0, 8'h08, '0);
        compare(rd, 32'h0000_0000);
        apb(1'b0, 8'h10, '0);
        compare(rd, 32'h0000_0000);
        apb(1'b0, 8'h0c, '0);
        compare(rd, 32'h0000_07ff);
        apb(1'b0, 8'h14, '0);
        compare(rd, 32'h1fff_ffff);
        summarize();
    end
endmodule
